// File: core/flash_status_pkg.sv
// shared types and constants for the flash status polling controller
// assumes an 8-bit flash data bus driven through strobe pins, 10 MHz clock
package flash_status_pkg;

	// ==========================================================
	// status bit positions on the data bus
	localparam int unsigned DATA_POLL_BIT   = 7;
	localparam int unsigned TOGGLE_ONE_BIT  = 6;
	localparam int unsigned TIMEOUT_BIT     = 5;
	localparam int unsigned ERASE_WIN_BIT   = 3;
	localparam int unsigned TOGGLE_TWO_BIT  = 2;

	// ==========================================================
	// command words and unlock addresses
	localparam logic [7:0]  CMD_UNLOCK_A    = 8'hAA;
	localparam logic [7:0]  CMD_UNLOCK_B    = 8'h55;
	localparam logic [7:0]  CMD_PROGRAM     = 8'hA0;
	localparam logic [7:0]  CMD_ERASE_SETUP = 8'h80;
	localparam logic [7:0]  CMD_CHIP_ERASE  = 8'h10;
	localparam logic [7:0]  CMD_SECT_ERASE  = 8'h30;
	localparam logic [7:0]  CMD_SUSPEND     = 8'hB0;
	localparam logic [7:0]  CMD_RESUME      = 8'h30;
	localparam logic [19:0] ADDR_UNLOCK_A   = 20'h00555;
	localparam logic [19:0] ADDR_UNLOCK_B   = 20'h002AA;

	// ==========================================================
	// timing: clock rate and strobe phase lengths
	localparam int unsigned CLK_MHZ         = 10;
	localparam int unsigned STROBE_NS       = 100;
	localparam int unsigned STROBE_CYC      = (STROBE_NS * CLK_MHZ + 999) / 1000;
	localparam int unsigned SUSPEND_US      = 15;
	localparam int unsigned SUSPEND_CYC     = SUSPEND_US * CLK_MHZ;
	localparam logic [1:0]  RESET_PHASE     = 2'h0;

	// ==========================================================
	// user operations
	typedef enum logic [2:0] {
		OP_READ    = 3'h0,
		OP_PROGRAM = 3'h1,
		OP_CHIP_ER = 3'h2,
		OP_SECT_ER = 3'h3,
		OP_SECT_ADD = 3'h4,
		OP_SUSPEND = 3'h5,
		OP_RESUME  = 3'h6
	} op_e;

	// request from the user side
	typedef struct packed {
		op_e         op;
		logic [19:0] addr;
		logic [7:0]  data;
	} request_s;

	// result to the user side
	typedef struct packed {
		logic       done;     // toggle bit one stopped, operation finished
		logic       failed;   // timeout seen on two read pairs, or program bit seven wrong
		logic       suspended;
		logic       window_open;
		logic       sector_erasing;
		logic [7:0] rdata;
	} result_s;

	// one bus cycle for the strobe engine
	typedef struct packed {
		logic        write;
		logic [19:0] addr;
		logic [7:0]  data;
	} bus_cycle_s;

endpackage

// File: core/flash_bus_cycle.sv
// strobe engine: performs one read or write cycle on the flash pins
// assumes the flash data pins are two-way; enable low means we drive
module flash_bus_cycle
	import flash_status_pkg::*;
#(
	parameter int unsigned PHASE_CYC = STROBE_CYC
) (
	input  wire logic        clock,
	input  wire logic        rst_n,
	input  wire logic        start,
	input  bus_cycle_s       cyc,
	output logic             busy,
	output logic             done,
	output logic [7:0]       rdata,
	output logic             chip_sel_n,
	output logic             read_n,
	output logic             write_n,
	output logic [19:0]      addr,
	output logic [7:0]       data_out,
	output logic             data_oe_n,
	input  wire logic [7:0]  data_in
);

	// ==========================================================
	// parameter checks
	initial begin
		if (PHASE_CYC < 1 || PHASE_CYC > 255) begin
			$error("phase length out of range");
		end
	end

	typedef enum logic [1:0] {
		CY_IDLE = 2'b00,
		CY_SET  = 2'b01,
		CY_ACT  = 2'b11,
		CY_END  = 2'b10
	} cyc_state_e;

	cyc_state_e  st_q, st_d;
	logic [7:0]  cnt_q, cnt_d;
	bus_cycle_s  cur_q, cur_d;
	logic [7:0]  rd_q, rd_d;
	logic [7:0]  sync1_q, sync2_q;

	// ==========================================================
	// input synchroniser for data pins
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			sync1_q <= 8'h00;
			sync2_q <= 8'h00;
		end else begin
			sync1_q <= data_in;
			sync2_q <= sync1_q;
		end
	end

	// next state of the cycle sequencer
	always_comb begin
		st_d  = st_q;
		cnt_d = cnt_q;
		cur_d = cur_q;
		rd_d  = rd_q;
		case (st_q)
			CY_IDLE: begin
				if (start) begin
					cur_d = cyc;
					st_d  = CY_SET;
					cnt_d = 8'h00;
				end
			end
			CY_SET: begin
				st_d  = CY_ACT;
				cnt_d = 8'h00;
			end
			CY_ACT: begin
				// two extra cycles cover the read synchroniser delay
				if (cnt_q >= 8'(PHASE_CYC + 1)) begin
					rd_d = sync2_q;
					st_d = CY_END;
				end else begin
					cnt_d = cnt_q + 8'h01;
				end
			end
			CY_END: begin
				st_d = CY_IDLE;
			end
			default: begin
				st_d = CY_IDLE;
			end
		endcase
	end

	// register the cycle sequencer
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			st_q  <= CY_IDLE;
			cnt_q <= 8'h00;
			cur_q <= '0;
			rd_q  <= 8'h00;
		end else begin
			st_q  <= st_d;
			cnt_q <= cnt_d;
			cur_q <= cur_d;
			rd_q  <= rd_d;
		end
	end

	// pin drive: chip select spans the whole cycle, strobe only the active phase
	// each read is a fresh strobe pair so the device advances its toggle bits
	assign busy       = (st_q != CY_IDLE);
	assign done       = (st_q == CY_END);
	assign rdata      = rd_q;
	// select stays low through the end phase so the write strobe rises first
	assign chip_sel_n = (st_q == CY_IDLE);
	assign read_n     = !(st_q == CY_ACT && !cur_q.write);
	assign write_n    = !(st_q == CY_ACT && cur_q.write);
	assign addr       = cur_q.addr;
	assign data_out   = cur_q.data;
	assign data_oe_n  = !(cur_q.write && st_q != CY_IDLE);

endmodule

// File: core/flash_status_poller.sv
// host-side controller that issues flash program/erase sequences and
// interprets the status flags read back from the data bus
// assumes a flash device on the pins, a single 10 MHz clock, user on req/res ports
//
// How it works
// RULE1 - during program, poll bit reads inverse of written bit seven until done
// RULE2 - during erase poll bit reads zero, reads one when erase finished
// RULE3 - suspend entry shows poll bit rising; host polls inside erasing sector
// RULE4 - program inside suspend polls exactly like ordinary program
// RULE5 - poll status valid after sixth chip-erase write or last sector write
// RULE6 - host polls erase status at an address inside an erasing sector
// RULE7 - poll bit may flip early; host re-reads for a full valid byte
// RULE8 - poll status only present during program, erase, suspend or window
// RULE9 - toggle bit one inverts each read while busy, stops when done
// RULE10 - toggle bit one valid after fourth program or sixth erase write
// RULE11 - program of protected sector toggles about two microseconds then stops
// RULE12 - erase of all-protected sectors toggles about hundred microseconds, then read
// RULE13 - toggle bit one advances on select or read strobe, suspend, resume
// RULE14 - timeout bit reads one on pulse-count overrun, zero otherwise
// RULE15 - after timeout only poll and toggle one still work
// RULE16 - programming zero to one locks device; host must reset it
// RULE17 - suspend read of suspended sector toggles bit two, poll and one read one
// RULE18 - program in suspend: programmed byte reads one on toggle two
// RULE19 - program in suspend keeps toggle one inverting until program finishes
// RULE20 - erase window bit zero while more sector commands accepted, one after
// RULE21 - erasing sector reads toggle bit two toggling during erase
// RULE22 - ready-busy goes low after fourth or sixth write, until algorithm ends
// RULE23 - status appears only with chip select and read strobe both low
module flash_status_poller
	import flash_status_pkg::*;
(
	input  wire logic        clock,
	input  wire logic        rst_n,
	input  wire logic        req_valid,
	output logic             req_ready,
	input  request_s         req,
	output logic             res_valid,
	output result_s          res,
	output logic             chip_sel_n,
	output logic             read_n,
	output logic             write_n,
	output logic             flash_reset_n,
	output logic [19:0]      addr,
	output logic [7:0]       data_out,
	output logic             data_oe_n,
	input  wire logic [7:0]  data_in,
	input  wire logic        ready_busy_n
);

	// ==========================================================
	// state machine
	typedef enum logic [2:0] {
		S_IDLE  = 3'b000,
		S_WRITE = 3'b001,
		S_POLL1 = 3'b011,
		S_POLL2 = 3'b010,
		S_CHECK = 3'b110,
		S_FINAL = 3'b111,
		S_RESET = 3'b101,
		S_DONE  = 3'b100
	} ctl_state_e;

	ctl_state_e  st_q, st_d;
	request_s    req_q, req_d;
	logic [2:0]  widx_q, widx_d;
	logic [7:0]  first_q, first_d;
	result_s     res_q, res_d;
	logic        susp_q, susp_d;
	logic        tmo_q, tmo_d;      // timeout bit seen once, awaiting confirmation
	logic        rst_pin_q, rst_pin_d;
	logic        rb1_q, rb2_q;
	logic        cyc_start;
	bus_cycle_s  cyc;
	logic        cyc_busy;
	logic        cyc_done;
	logic [7:0]  cyc_rdata;

	// number of writes in each command sequence
	function automatic logic [2:0] seq_len(input op_e op);
		case (op)
			OP_PROGRAM: seq_len = 3'h4;
			OP_CHIP_ER: seq_len = 3'h6;
			OP_SECT_ER: seq_len = 3'h6;
			default:    seq_len = 3'h1;
		endcase
	endfunction

	// one write of a command sequence, by index
	function automatic bus_cycle_s seq_cycle(input request_s r, input logic [2:0] i);
		bus_cycle_s c;
		c.write = 1'b1;
		// second unlock write of each pair goes to the other address
		c.addr  = (i == 3'h1 || i == 3'h4) ? ADDR_UNLOCK_B : ADDR_UNLOCK_A;
		c.data  = (i == 3'h1 || i == 3'h4) ? CMD_UNLOCK_B : CMD_UNLOCK_A;
		case (r.op)
			OP_PROGRAM: begin
				if (i == 3'h2) c.data = CMD_PROGRAM;
				if (i == 3'h3) begin
					c.addr = r.addr;
					c.data = r.data;
				end
			end
			OP_CHIP_ER, OP_SECT_ER: begin
				if (i == 3'h2) c.data = CMD_ERASE_SETUP;
				if (i == 3'h5) begin
					c.data = (r.op == OP_CHIP_ER) ? CMD_CHIP_ERASE : CMD_SECT_ERASE;
					c.addr = (r.op == OP_CHIP_ER) ? ADDR_UNLOCK_A : r.addr;
				end
			end
			OP_SECT_ADD: begin
				c.addr = r.addr;
				c.data = CMD_SECT_ERASE;
			end
			OP_SUSPEND: c.data = CMD_SUSPEND;
			OP_RESUME:  c.data = CMD_RESUME;
			default:    c.data = CMD_UNLOCK_A;
		endcase
		return c;
	endfunction

	// ==========================================================
	// ready-busy pin synchroniser
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			rb1_q <= 1'b1;
			rb2_q <= 1'b1;
		end else begin
			rb1_q <= ready_busy_n;
			rb2_q <= rb1_q;
		end
	end

	// next state: sequence writes, then two-read toggle polling
	always_comb begin
		st_d      = st_q;
		req_d     = req_q;
		widx_d    = widx_q;
		first_d   = first_q;
		res_d     = res_q;
		susp_d    = susp_q;
		tmo_d     = tmo_q;
		rst_pin_d = 1'b1;
		cyc_start = 1'b0;
		cyc       = '0;
		case (st_q)
			S_IDLE: begin
				if (req_valid) begin
					req_d  = req;
					widx_d = 3'h0;
					tmo_d  = 1'b0;
					res_d  = '0;
					st_d   = (req.op == OP_READ) ? S_FINAL : S_WRITE;
				end
			end
			S_WRITE: begin
				cyc       = seq_cycle(req_q, widx_q);
				cyc_start = !cyc_busy;
				if (cyc_done) begin
					if (widx_q == seq_len(req_q.op) - 3'h1) begin
						// RULE5 status valid now
						// RULE10 after last strobe
						st_d = S_POLL1;
					end else begin
						widx_d = widx_q + 3'h1;
					end
				end
			end
			S_POLL1: begin
				// RULE6 poll at target sector
				// RULE13 each read toggles select and strobe
				cyc.addr  = req_q.addr;
				cyc_start = !cyc_busy;
				if (cyc_done) begin
					first_d = cyc_rdata;
					st_d    = S_POLL2;
				end
			end
			S_POLL2: begin
				cyc.addr  = req_q.addr;
				cyc_start = !cyc_busy;
				if (cyc_done) begin
					st_d = S_CHECK;
					// RULE20 window flag reporting
					res_d.window_open = !cyc_rdata[ERASE_WIN_BIT];
					// RULE9 toggle one stopped means done
					// RULE11 protected program stops toggling too
					// RULE12 protected erase returns to read
					if (cyc_rdata[TOGGLE_ONE_BIT] == first_q[TOGGLE_ONE_BIT]) begin
						// RULE3 suspend entered: poll one, toggle one steady
						if (req_q.op == OP_SUSPEND) begin
							susp_d = 1'b1;
						end
						res_d.done = 1'b1;
						// RULE7 re-read for valid full byte
						st_d = S_FINAL;
					// RULE14 timeout bit raised
					// RULE15 only toggle still runs
					end else if (cyc_rdata[TIMEOUT_BIT] && tmo_q) begin
						res_d.failed = 1'b1;
						// RULE16 lockup needs device reset
						st_d = S_RESET;
						widx_d = 3'h0;
					end else begin
						// RULE1 program poll inverts bit seven
						// RULE2 erase poll reads zero
						// RULE4 same in suspend
						// RULE19 keep polling
						st_d = S_POLL1;
						// RULE14 timeout on a finishing read needs a second pair
						tmo_d = cyc_rdata[TIMEOUT_BIT];
						// RULE21 erasing sector shows toggle two
						// RULE17 suspended sector shows toggle two
						res_d.sector_erasing = res_q.sector_erasing
							| (cyc_rdata[TOGGLE_TWO_BIT] ^ first_q[TOGGLE_TWO_BIT]);
					end
				end
			end
			S_RESET: begin
				rst_pin_d = 1'b0;
				widx_d    = widx_q + 3'h1;
				if (widx_q == 3'h7) begin
					susp_d = 1'b0;
					st_d   = S_DONE;
				end
			end
			S_FINAL: begin
				cyc.addr  = req_q.addr;
				cyc_start = !cyc_busy;
				if (cyc_done) begin
					res_d.rdata = cyc_rdata;
					// RULE1 true data bit seven on completion
					if (req_q.op == OP_PROGRAM && cyc_rdata[DATA_POLL_BIT] != req_q.data[DATA_POLL_BIT]) begin
						res_d.failed = 1'b1;
					end
					st_d = S_DONE;
				end
			end
			S_DONE: begin
				if (req_q.op == OP_RESUME) begin
					susp_d = 1'b0;
				end
				res_d.suspended = susp_d;
				st_d = S_IDLE;
			end
			default: st_d = S_IDLE;
		endcase
	end

	// register controller state
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			st_q      <= S_IDLE;
			req_q     <= '0;
			widx_q    <= 3'h0;
			first_q   <= 8'h00;
			res_q     <= '0;
			susp_q    <= 1'b0;
			tmo_q     <= 1'b0;
			rst_pin_q <= 1'b0;
		end else begin
			st_q      <= st_d;
			req_q     <= req_d;
			widx_q    <= widx_d;
			first_q   <= first_d;
			res_q     <= res_d;
			susp_q    <= susp_d;
			tmo_q     <= tmo_d;
			rst_pin_q <= rst_pin_d;
		end
	end

	// RULE23 reads only with select and strobe low
	flash_bus_cycle u_cycle (
		.clock      (clock),
		.rst_n      (rst_n),
		.start      (cyc_start),
		.cyc        (cyc),
		.busy       (cyc_busy),
		.done       (cyc_done),
		.rdata      (cyc_rdata),
		.chip_sel_n (chip_sel_n),
		.read_n     (read_n),
		.write_n    (write_n),
		.addr       (addr),
		.data_out   (data_out),
		.data_oe_n  (data_oe_n),
		.data_in    (data_in)
	);

	assign req_ready     = (st_q == S_IDLE);
	assign res_valid     = (st_q == S_DONE);
	assign res           = res_q;
	assign flash_reset_n = rst_pin_q;

	// ==========================================================
	// checks
	a_ready_low_busy: assert property (@(posedge clock) disable iff (!rst_n)
		((st_q == S_POLL1 || st_q == S_POLL2) && !rb2_q) |-> write_n)
		else $error("write while device busy"); // RULE22

	a_reset_pulse_len: assert property (@(posedge clock) disable iff (!rst_n)
		$fell(flash_reset_n) |-> !flash_reset_n [*8]) else $error("reset pulse short"); // RULE16

	a_strobes_apart: assert property (@(posedge clock) disable iff (!rst_n)
		!(read_n == 1'b0 && write_n == 1'b0)) else $error("read and write together"); // RULE23

	a_read_under_sel: assert property (@(posedge clock) disable iff (!rst_n)
		!read_n |-> !chip_sel_n && data_oe_n) else $error("read without select"); // RULE23

	a_poll_after_seq: assert property (@(posedge clock) disable iff (!rst_n)
		(st_q == S_WRITE && st_d == S_POLL1) |-> widx_q == seq_len(req_q.op) - 3'h1)
		else $error("poll before last write"); // RULE5

	a_done_on_stop: assert property (@(posedge clock) disable iff (!rst_n)
		(st_q == S_POLL2 && cyc_done && cyc_rdata[TOGGLE_ONE_BIT] == first_q[TOGGLE_ONE_BIT])
		|=> res_q.done && st_q == S_FINAL) else $error("stop not seen"); // RULE9

	a_fail_on_timeout: assert property (@(posedge clock) disable iff (!rst_n)
		(st_q == S_POLL2 && cyc_done && cyc_rdata[TOGGLE_ONE_BIT] != first_q[TOGGLE_ONE_BIT]
		&& cyc_rdata[TIMEOUT_BIT] && tmo_q) |=> res_q.failed ##1 !flash_reset_n)
		else $error("timeout missed"); // RULE14

	a_timeout_confirm: assert property (@(posedge clock) disable iff (!rst_n)
		(st_q == S_POLL2 && cyc_done && cyc_rdata[TOGGLE_ONE_BIT] != first_q[TOGGLE_ONE_BIT]
		&& cyc_rdata[TIMEOUT_BIT] && !tmo_q) |=> st_q == S_POLL1 && tmo_q)
		else $error("timeout not confirmed"); // RULE14

	a_keep_polling: assert property (@(posedge clock) disable iff (!rst_n)
		(st_q == S_POLL2 && cyc_done && cyc_rdata[TOGGLE_ONE_BIT] != first_q[TOGGLE_ONE_BIT]
		&& !cyc_rdata[TIMEOUT_BIT]) |=> st_q == S_POLL1) else $error("polling stopped early"); // RULE19

endmodule

// File: testbench/flash_status_device.sv
// behavioural flash device: status flags replace data while an algorithm runs
// assumes strobes from the poller; algorithm lengths are counted in reads
module flash_status_device
	import flash_status_pkg::*;
#(
	parameter int unsigned PROG_READS  = 5,
	parameter int unsigned PROT_READS  = 3,
	parameter int unsigned LOCK_READS  = 4,
	parameter int unsigned ERASE_READS = 8,
	parameter int unsigned WIN_READS   = 2,
	parameter logic [3:0]  PROT_SECT   = 4'hF
) (
	input  wire logic        chip_sel_n,
	input  wire logic        read_n,
	input  wire logic        write_n,
	input  wire logic        flash_reset_n,
	input  wire logic [19:0] addr,
	input  wire logic [7:0]  host_data,
	input  wire logic        host_oe_n,
	output logic [7:0]       data_lvl,
	output logic             drv_en,
	output logic             ready_busy_n
);
	timeunit 1ns;
	timeprecision 1ns;

	// ==========================================================
	// state
	logic [7:0] mem [0:255];
	logic [7:0] q, hold, pd;
	logic [3:0] es;
	logic [2:0] seq;
	logic [1:0] mode;   // 0 read, 1 program, 2 erase, 3 erase window
	logic       t1, t2, fail, lock, chip;
	int         left, nrd;
	wire        rd_n = chip_sel_n | read_n;

	// sector in the top nibble, byte in the low nibble
	function automatic logic [7:0] idx(input logic [19:0] a);
		return {a[19:16], a[3:0]};
	endfunction

	// power-up contents erased
	initial begin
		for (int i = 0; i < 256; i++) mem[i] = 8'hFF;
		{mode, seq, t1, t2, fail, lock, chip, q, hold, es} = '0;
	end

	always @(negedge flash_reset_n) begin
		mode = 2'h0;
		seq = 3'h0;
		fail = 1'b0;
		lock = 1'b0;
	end

	// ==========================================================
	// command writes, latched on the rising write strobe
	// algorithm starts at last write
	always @(posedge write_n) if (!chip_sel_n) begin
		if (mode == 2'h3 && host_data == CMD_SECT_ERASE) begin
			left = WIN_READS;
		end else if (mode == 2'h0) begin
			case (seq)
			3'h0, 3'h4: seq = (host_data == CMD_UNLOCK_A && addr == ADDR_UNLOCK_A) ? seq + 3'h1 : 3'h0;
			3'h1, 3'h5: seq = (host_data == CMD_UNLOCK_B && addr == ADDR_UNLOCK_B) ? seq + 3'h1 : 3'h0;
			3'h2: seq = (host_data == CMD_PROGRAM) ? 3'h3 : (host_data == CMD_ERASE_SETUP) ? 3'h4 : 3'h0;
			3'h3: begin
				pd = host_data;
				nrd = 0;
				mode = 2'h1;
				// zero to one hangs the algorithm
				lock = |(host_data & ~mem[idx(addr)]);
				// protected sector toggles briefly, data kept
				left = (addr[19:16] == PROT_SECT) ? PROT_READS : PROG_READS;
				if (!lock && addr[19:16] != PROT_SECT) mem[idx(addr)] = host_data;
				seq = 3'h0;
			end
			default: begin
				es = addr[19:16];
				chip = (host_data == CMD_CHIP_ERASE);
				mode = chip ? 2'h2 : 2'h3;
				left = chip ? ERASE_READS : WIN_READS;
				seq = 3'h0;
			end
			endcase
		end
	end

	// ==========================================================
	// reads: status while busy, data otherwise
	// each read strobe advances toggle one
	always @(negedge rd_n) begin
		case (mode)
		2'h1: q = {~pd[7], t1, fail, 2'b00, 1'b1, 2'b00};
		// erase reads zero, toggle two in sector
		2'h2: q = {1'b0, t1, fail, 1'b0, 1'b1, t2, 2'b00};
		2'h3: q = {1'b0, t1, 1'b0, 1'b0, 1'b0, t2, 2'b00};
		// plain data when no algorithm runs
		default: q = mem[idx(addr)];
		endcase
		t1 = ~t1;
		if (mode[1] && (chip || addr[19:16] == es)) t2 = ~t2;
		if (mode != 2'h0) begin
			nrd++;
			if (lock) fail = (nrd >= LOCK_READS);
			else if (left > 1) left--;
			else if (mode == 2'h3) begin
				mode = 2'h2;
				left = ERASE_READS;
			end else begin
				if (mode == 2'h2) begin
					// protected sectors are skipped by erase
					for (int i = 0; i < 256; i++)
						if ((chip || i[7:4] == es) && i[7:4] != PROT_SECT) mem[i] = 8'hFF;
				end
				// finishing read: true bit seven, rest unsettled
				q = {mem[idx(addr)][7], ~mem[idx(addr)][6:0]};
				mode = 2'h0;
			end
		end
	end

	// drive only while selected and reading
	assign drv_en = !rd_n;
	// busy from the last command write to the end
	assign ready_busy_n = (mode == 2'h0);

	// released pins show the inverse of the last level
	always @* begin
		if (drv_en) hold = q;
		else if (!host_oe_n) hold = host_data;
		data_lvl = drv_en ? q : (!host_oe_n ? host_data : ~hold);
	end

endmodule

// File: testbench/test_flash_status_poller.sv
// self-checking bench: user requests into the poller, device model on the pins
// assumes the poller package and the behavioural flash device model
module test_flash_status_poller
	import flash_status_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;

	// ==========================================================
	// signals and scenario table
	typedef struct packed {
		op_e         op;
		logic [19:0] a;
		logic [7:0]  d;
		logic [7:0]  rd;
		logic        dn;
		logic        fl;
		logic [2:0]  m;   // which of rdata, done, failed to compare
	} step_s;

	logic        clock, rst_n, req_valid, req_ready, res_valid;
	logic        chip_sel_n, read_n, write_n, flash_reset_n, data_oe_n, drv_en, ready_busy_n;
	logic [19:0] addr;
	logic [7:0]  data_out, data_in;
	request_s    req;
	result_s     res, got;
	int          fail_count, n_compared;

	step_s steps [0:13] = '{
		'{OP_READ,    20'h00010, 8'h00, 8'hFF, 1'b0, 1'b0, 3'b100},
		'{OP_PROGRAM, 20'h00010, 8'h5A, 8'h5A, 1'b1, 1'b0, 3'b111},
		'{OP_PROGRAM, 20'h00011, 8'h33, 8'h33, 1'b1, 1'b0, 3'b111},
		'{OP_READ,    20'h00010, 8'h00, 8'h5A, 1'b0, 1'b0, 3'b100},
		'{OP_PROGRAM, 20'hF0001, 8'h12, 8'hFF, 1'b0, 1'b1, 3'b101},
		'{OP_PROGRAM, 20'h00010, 8'hFF, 8'h00, 1'b0, 1'b1, 3'b011},
		'{OP_READ,    20'h00010, 8'h00, 8'h5A, 1'b0, 1'b0, 3'b100},
		'{OP_CHIP_ER, 20'h00010, 8'h00, 8'hFF, 1'b1, 1'b0, 3'b111},
		'{OP_READ,    20'h00011, 8'h00, 8'hFF, 1'b0, 1'b0, 3'b100},
		'{OP_PROGRAM, 20'h30005, 8'h00, 8'h00, 1'b1, 1'b0, 3'b111},
		'{OP_PROGRAM, 20'h00011, 8'h33, 8'h33, 1'b1, 1'b0, 3'b111},
		'{OP_SECT_ER, 20'h30005, 8'h00, 8'hFF, 1'b1, 1'b0, 3'b111},
		'{OP_READ,    20'h00011, 8'h00, 8'h33, 1'b0, 1'b0, 3'b100},
		'{OP_READ,    20'h30005, 8'h00, 8'hFF, 1'b0, 1'b0, 3'b100}
	};

	initial clock = 1'b0;
	always #50 clock = ~clock;

	// ==========================================================
	// design and device model
	flash_status_poller flash_status_poller_inst (
		.clock         (clock),
		.rst_n         (rst_n),
		.req_valid     (req_valid),
		.req_ready     (req_ready),
		.req           (req),
		.res_valid     (res_valid),
		.res           (res),
		.chip_sel_n    (chip_sel_n),
		.read_n        (read_n),
		.write_n       (write_n),
		.flash_reset_n (flash_reset_n),
		.addr          (addr),
		.data_out      (data_out),
		.data_oe_n     (data_oe_n),
		.data_in       (data_in),
		.ready_busy_n  (ready_busy_n)
	);

	flash_status_device flash_status_device_inst (
		.chip_sel_n    (chip_sel_n),
		.read_n        (read_n),
		.write_n       (write_n),
		.flash_reset_n (flash_reset_n),
		.addr          (addr),
		.host_data     (data_out),
		.host_oe_n     (data_oe_n),
		.data_lvl      (data_in),
		.drv_en        (drv_en),
		.ready_busy_n  (ready_busy_n)
	);

	// ==========================================================
	// compare, request and closing tasks
	task automatic check_byte(input string name, input logic [7:0] exp, input logic [7:0] seen);
		n_compared++;
		if (seen !== exp) begin
			fail_count++;
			$display("BAD %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic check_flag(input string name, input logic exp, input logic seen);
		n_compared++;
		if (seen !== exp) begin
			fail_count++;
			$display("BAD %s expected %b seen %b", name, exp, seen);
		end
	endtask

	// offer one request, hold it until taken, wait for the answer
	task automatic do_op(input step_s s);
		int n;
		@(negedge clock);
		req = '{op: s.op, addr: s.a, data: s.d};
		req_valid = 1'b1;
		for (n = 0; n < 100 && req_ready !== 1'b1; n++) @(negedge clock);
		@(negedge clock);
		req_valid = 1'b0;
		check_flag("req_ready while busy", 1'b0, req_ready);
		for (n = 0; n < 20000 && res_valid !== 1'b1; n++) @(negedge clock);
		check_flag("res_valid", 1'b1, res_valid);
		@(negedge clock);
		got = res;
	endtask

	task automatic final_report();
		$display("compared %0d mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	// the two sides never drive the data pins together
	always @(negedge clock) if (drv_en && data_oe_n === 1'b0) begin
		fail_count++;
		$display("BAD data pin contention expected %b seen %b", 1'b1, data_oe_n);
	end

	// ==========================================================
	// main sequence
	initial begin
		rst_n = 1'b0;
		req_valid = 1'b0;
		req = '0;
		fail_count = 0;
		n_compared = 0;
		repeat (20) @(negedge clock);
		check_flag("chip_sel_n in reset", 1'b1, chip_sel_n);
		check_flag("data_oe_n in reset", 1'b1, data_oe_n);
		rst_n = 1'b1;
		repeat (2) @(negedge clock);
		check_flag("flash_reset_n after reset", 1'b1, flash_reset_n);
		for (int i = 0; i < 14; i++) begin
			do_op(steps[i]);
			if (steps[i].m[2]) check_byte("rdata", steps[i].rd, got.rdata);
			if (steps[i].m[1]) check_flag("done", steps[i].dn, got.done);
			if (steps[i].m[0]) check_flag("failed", steps[i].fl, got.failed);
			if (i == 11) check_flag("sector_erasing", 1'b1, got.sector_erasing);
			$display("test %0d %s done", i, steps[i].op.name());
		end
		final_report();
	end

	// watchdog far beyond the expected run length
	initial begin
		repeat (30000) @(posedge clock);
		fail_count++;
		final_report();
	end

endmodule
